/* bench/ssp_cmd_sva.sv */
// Port assertions of the serial flash command interpreter
`timescale 1ns/1ps
module ssp_cmd_chk (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_serial_transfer_clock_pin,
  input wire logic o_busy_handshake_output,
  input wire logic o_mode1_active,
  input wire logic o_mem_rd_req,
  input wire logic [23:0] o_mem_addr,
  input wire logic i_mem_rd_valid,
  input wire logic o_prog_valid,
  input wire logic [7:0] o_prog_data,
  input wire logic i_prog_ready,
  input wire logic o_prog_start,
  input wire logic o_erase_block,
  input wire logic o_erase_all,
  input wire logic i_op_done
);
  logic op;
  logic pend_ff;
  assign op = o_prog_start | o_erase_block | o_erase_all;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  ////////////////////////////////////////////////////////////////////////////////
  // Remembers a started operation until the flash side ends it
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || i_op_done) pend_ff <= 1'b0;
    else if (op) pend_ff <= 1'b1;
  end
  property p_nomode; !o_mode1_active |-> o_busy_handshake_output; endproperty
  a_nomode: assert property (p_nomode) else $error("ready outside mode one");
  property p_keep; o_mode1_active |=> o_mode1_active; endproperty
  a_keep: assert property (p_keep) else $error("mode select lost");
  property p_start;
    $fell(i_serial_transfer_clock_pin) && !o_busy_handshake_output && o_mode1_active
      |-> ##[1:6] o_busy_handshake_output;
  endproperty
  a_start: assert property (p_start) else $error("busy not raised by transfer");
  property p_pend; pend_ff |-> o_busy_handshake_output; endproperty
  a_pend: assert property (p_pend) else $error("ready while operation runs");
  property p_pulse; op |=> !op; endproperty
  a_pulse: assert property (p_pulse) else $error("start pulse too long");
  property p_excl; $onehot0({o_prog_start, o_erase_block, o_erase_all}); endproperty
  a_excl: assert property (p_excl) else $error("two operations at once");
  property p_drain; o_prog_start |-> !o_prog_valid; endproperty
  a_drain: assert property (p_drain) else $error("program before drain");
  property p_hold;
    o_prog_valid && !i_prog_ready |=> o_prog_valid && $stable(o_prog_data);
  endproperty
  a_hold: assert property (p_hold) else $error("write data dropped");
  property p_rdreq;
    o_mem_rd_req && !i_mem_rd_valid |=> o_mem_rd_req && $stable(o_mem_addr);
  endproperty
  a_rdreq: assert property (p_rdreq) else $error("read request not held");
endmodule
bind ssp_cmd_top ssp_cmd_chk chk_u (.*);

/* bench/ssp_cmd_top_tb.sv */
// Self-checking bench of the serial flash command interpreter
`timescale 1ns/1ps
module ssp_cmd_top_tb
  import ssp_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, blank = 1'b0, rdv = 1'b0, prdy = 1'b0, done = 1'b0;
  logic err = 1'b0, sclk, rxd, txd, busy, mode1, rdreq, pv, pstart, eblk, eall, got;
  logic [55:0] idc;
  logic [23:0] maddr;
  logic [15:0] pg;
  logic [7:0] rdat = 8'h00, pd, rbyte;
  logic [31:0] seed = 32'h913a_ca5b, r, q;
  logic [7:0] exp_q[$], prog_q[$];
  int mismatches = 0, tests_run = 0, ops = 0, dly = 0, st = 0;
  ssp_cmd_top dut_u (.i_ref_clk(clk), .i_reset(rst), .i_serial_transfer_clock_pin(sclk),
    .i_serial_receive_line(rxd), .o_serial_transmit_line(txd),
    .o_busy_handshake_output(busy), .o_mode1_active(mode1), .i_flash_blank(blank),
    .i_id_code(idc), .o_mem_rd_req(rdreq), .o_mem_addr(maddr), .i_mem_rd_valid(rdv),
    .i_mem_rd_data(rdat), .o_prog_valid(pv), .o_prog_data(pd), .i_prog_ready(prdy),
    .o_prog_start(pstart), .o_erase_block(eblk), .o_erase_all(eall), .i_op_done(done),
    .i_op_error(err));
  ssp_prog_model pm_u (.i_busy(busy), .i_tx(txd), .o_sclk(sclk), .o_rxd(rxd),
    .o_byte(rbyte), .o_got(got));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic tx(input logic [7:0] b);
    pm_u.xfer(b, 1'b0);
  endtask
  // Notes the expected byte, then clocks it out of the device
  task automatic rx(input logic [7:0] e);
    exp_q.push_back(e);
    pm_u.xfer(8'h00, 1'b1);
  endtask
  task automatic stat(input logic ee, input logic pe, input logic id);
    tx(SSP_CMD_RD_STATUS);
    rx({2'b00, ee, pe, 4'h0});
    rx({5'h00, id, 2'b00});
  endtask
  task automatic idchk(input logic [55:0] v);
    tx(SSP_CMD_ID_CHECK);
    repeat (3) tx(8'h00);
    tx(SSP_ID_LEN);
    for (int k = 0; k < 7; k++) tx(v[8*k +: 8]);
  endtask
  task automatic page(input logic [7:0] c);
    tx(c);
    tx(pg[7:0]);
    tx(pg[15:8]);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial forever #20 clk = ~clk;
  // Flash side: random read latency, a long early stall, operation completion
  always @(negedge clk) begin
    q = xs();
    prdy <= (q[0] | q[1]) && st >= 1000;
    if (pv && st < 1000) st++;
    rdv <= rdreq && !rdv && q[2];
    rdat <= maddr[7:0] ^ maddr[15:8] ^ maddr[23:16];
    done <= (dly == 1);
    if (dly != 0) dly <= dly - 1;
    if (pstart || eblk || eall) begin
      ops++;
      dly <= 6;
    end
    if (pstart || eblk) cmp(maddr[23:8], pg);
  end
  // Returned bytes against the oldest note
  always @(posedge got) cmp(rbyte, exp_q.pop_front());
  // Write data must leave the buffer in arrival order
  always @(posedge clk) if (pv && prdy && !rst) cmp(pd, prog_q.pop_front());
  initial begin
    r = xs();
    idc = {r[23:0], xs()};
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    cmp(mode1, 1);
    tx(SSP_CMD_ERASE_ALL);
    tx(SSP_CMD_CONFIRM);
    tx(8'h13);
    stat(1'b0, 1'b0, 1'b0);
    cmp(ops, 0);
    tx(SSP_CMD_VERSION);
    for (int i = 0; i < 8; i++) rx(SSP_VERSION[63-8*i -: 8]);
    idchk(idc ^ 56'h1);
    stat(1'b0, 1'b0, 1'b0);
    idchk(idc);
    stat(1'b0, 1'b0, 1'b1);
    r = xs();
    pg = r[15:0];
    page(SSP_CMD_PAGE_READ);
    for (int i = 0; i < 256; i++) rx(i[7:0] ^ pg[7:0] ^ pg[15:8]);
    @(negedge clk) err = 1'b1;
    page(SSP_CMD_PAGE_PROG);
    for (int i = 0; i < 256; i++) begin
      r = xs();
      prog_q.push_back(r[7:0]);
      tx(r[7:0]);
    end
    stat(1'b0, 1'b1, 1'b1);
    tx(SSP_CMD_CLR_STATUS);
    stat(1'b0, 1'b0, 1'b1);
    @(negedge clk) err = 1'b0;
    tx(SSP_CMD_ERASE_ALL);
    tx(8'h11);
    tx(SSP_CMD_ERASE_ALL);
    tx(SSP_CMD_CONFIRM);
    stat(1'b0, 1'b0, 1'b1);
    @(negedge clk) err = 1'b1;
    page(SSP_CMD_BLK_ERASE);
    tx(SSP_CMD_CONFIRM);
    stat(1'b1, 1'b0, 1'b1);
    cmp(ops, 3);
    @(negedge clk) rst = 1'b1;
    blank = 1'b1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    tx(SSP_CMD_ERASE_ALL);
    tx(SSP_CMD_CONFIRM);
    tx(8'h13);
    cmp(ops, 4);
    print_verdict();
  end
  // Hang guard, well past the expected run length
  initial begin
    #3_000_000;
    mismatches++;
    print_verdict();
  end
endmodule

/* bench/ssp_prog_model.sv */
// Programmer model: drives the transfer clock and swaps bytes
`timescale 1ns/1ps
module ssp_prog_model (
  input wire logic i_busy,
  input wire logic i_tx,
  output logic o_sclk,
  output logic o_rxd,
  output logic [7:0] o_byte,
  output logic o_got
);
  initial begin
    o_sclk = 1'b1;
    o_rxd = 1'b1;
    o_byte = 8'h00;
    o_got = 1'b0;
  end
  // Free phase against the device clock, so edges land anywhere
  task automatic xfer(input logic [7:0] d, input logic chk);
    int n;
    n = 0;
    #13;
    while (i_busy !== 1'b0 && n < 20000) begin
      #40;
      n++;
    end
    for (int i = 0; i < 8; i++) begin
      o_sclk = 1'b0;
      o_rxd = d[i];
      #160;
      o_sclk = 1'b1;
      o_byte[i] = i_tx;
      #160;
    end
    // Idle line shows the inverse, never a stale bit
    o_rxd = ~o_rxd;
    o_got = chk;
    #40;
    o_got = 1'b0;
  endtask
endmodule

/* design/ssp_cmd_top.sv */
// Serial flash programming command interpreter with its write-data FIFO
//
// Behaviour
// - Clock pin high at reset release selects clock-synchronous programming mode.
// - Receive bits are sampled on each rising edge of the transfer clock.
// - Transmit bits change on each falling edge of the transfer clock.
// - Each transfer is one byte, least significant bit first.
// - Busy is high while transferring, erasing or programming, low when ready.
// - Read command plus two address bytes returns the page, lowest address first.
// - Program command plus two address bytes takes 256 bytes, then programs.
// - During page program busy drops once ready for more bytes.
// - Status read returns primary status then comm status.
// - Clear status clears both error flags, then drops busy.
// - Without verified ID only status read, ID check and version are taken.
// - A blank flash takes every command without ID verification.
// - Block erase is command, two address bytes, confirm byte starting erase.
// - Full erase is command then confirm byte starting erase.
// - ID check is command, three address bytes, length, then ID bytes.
// - Version command returns eight ASCII characters from the second byte.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Plain FIFO on flip-flops
module ssp_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  output logic o_ready,
  output logic o_valid,
  output logic [W-1:0] o_data,
  input wire logic i_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic do_wr;
  logic do_rd;

  // Full and empty both come from the word count
  assign o_ready = (count != (AW+1)'(D));
  assign o_valid = (count != '0);
  assign o_data = mem[rptr];
  assign do_wr = i_valid && o_ready;
  assign do_rd = o_valid && i_ready;

  // Pointers wrap since depth is a power of two
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      if (do_wr) begin
        mem[wptr] <= i_data;
        wptr <= wptr + AW'(1);
      end
      if (do_rd) begin
        rptr <= rptr + AW'(1);
      end
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Command interpreter
module ssp_cmd_top
  import ssp_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_serial_transfer_clock_pin,
  input wire logic i_serial_receive_line,
  output logic o_serial_transmit_line,
  output logic o_busy_handshake_output,
  output logic o_mode1_active,
  input wire logic i_flash_blank,
  input wire logic [55:0] i_id_code,
  output logic o_mem_rd_req,
  output logic [23:0] o_mem_addr,
  input wire logic i_mem_rd_valid,
  input wire logic [7:0] i_mem_rd_data,
  output logic o_prog_valid,
  output logic [7:0] o_prog_data,
  input wire logic i_prog_ready,
  output logic o_prog_start,
  output logic o_erase_block,
  output logic o_erase_all,
  input wire logic i_op_done,
  input wire logic i_op_error
);
  ssp_regs_t s;
  ssp_regs_t n;
  logic fifo_in_ready;
  logic rise;
  logic fall;
  logic byte_done;
  logic [7:0] rxbyte;
  logic allowed;
  logic [7:0] primary_status_register;
  logic [7:0] comm_status_register;

  // Write data waits here so the flash side may stall without losing bytes
  ssp_fifo #(
    .W(SSP_FIFO_W),
    .D(SSP_FIFO_D)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_valid(s.push.valid),
    .i_data(s.push.data),
    .o_ready(fifo_in_ready),
    .o_valid(o_prog_valid),
    .o_data(o_prog_data),
    .i_ready(i_prog_ready)
  );

  // Version character i, first character in the top byte; index wraps so
  // the look-ahead past the last character never reads outside the text
  function automatic logic [7:0] ver_char(input logic [7:0] i);
    ver_char = SSP_VERSION[8'(8'(63) - {i[2:0], 3'h0}) -: 8];
  endfunction

  // Edges seen only after the second synchroniser stage
  assign rise = s.clk_s2 && !s.clk_q;
  assign fall = !s.clk_s2 && s.clk_q;
  assign byte_done = s.mode1 && rise && (s.bitcnt == SSP_BIT_LAST);
  assign rxbyte = {s.rx_s2, s.rxsh[7:1]};
  assign allowed = s.id_ok || i_flash_blank;
  assign primary_status_register = 8'(!s.busy) << SSP_SR_READY | 8'(s.erase_err) << SSP_SR_ERASE_ERR
    | 8'(s.prog_err) << SSP_SR_PROG_ERR;
  assign comm_status_register = 8'(s.id_ok) << SSP_SR1_ID_OK;

  // Next-state logic for the whole block
  always_comb begin
    n = s;
    n.clk_s1 = i_serial_transfer_clock_pin;
    n.clk_s2 = s.clk_s1;
    n.clk_q = s.clk_s2;
    n.rx_s1 = i_serial_receive_line;
    n.rx_s2 = s.rx_s1;
    n.rd_req = s.rd_req && !i_mem_rd_valid;
    n.erase_blk = 1'b0;
    n.erase_all = 1'b0;
    n.prog_start = 1'b0;
    n.push = '0;
    // strap caught once the synchroniser has settled
    if (s.strap_cnt != 2'h3) begin
      n.strap_cnt = s.strap_cnt + 2'h1;
      if (s.strap_cnt == SSP_STRAP_AT) begin
        n.mode1 = s.clk_s2;
      end
    end
    // sample on rise; LSB arrives first
    if (s.mode1 && rise) begin
      n.rxsh = rxbyte;
      n.bitcnt = s.bitcnt + 3'h1;
    end
    // shift out on fall, LSB first
    if (s.mode1 && fall) begin
      n.tx = s.txsh[0];
      n.txsh = {1'b1, s.txsh[7:1]};
      n.inxfer = 1'b1;
    end
    if (byte_done) begin
      n.inxfer = 1'b0;
    end
    case (s.st)
      SSP_ST_CMD: begin
        if (byte_done) begin
          n.cnt = '0;
          case (rxbyte)
            SSP_CMD_PAGE_READ: if (allowed) begin
              n.st = SSP_ST_ADDR;
              n.kind = SSP_K_READ;
            end
            SSP_CMD_PAGE_PROG: if (allowed) begin
              n.st = SSP_ST_ADDR;
              n.kind = SSP_K_PROG;
            end
            SSP_CMD_BLK_ERASE: if (allowed) begin
              n.st = SSP_ST_ADDR;
              n.kind = SSP_K_ERASE;
            end
            SSP_CMD_ERASE_ALL: if (allowed) begin
              n.st = SSP_ST_CONFIRM;
              n.kind = SSP_K_ERALL;
            end
            SSP_CMD_CLR_STATUS: if (allowed) begin
              n.prog_err = 1'b0;
              n.erase_err = 1'b0;
            end
            SSP_CMD_RD_STATUS: begin
              n.st = SSP_ST_TXSEQ;
              n.kind = SSP_K_STAT;
              n.txsh = primary_status_register;
            end
            SSP_CMD_ID_CHECK: begin
              n.st = SSP_ST_ADDR;
              n.kind = SSP_K_ID;
            end
            SSP_CMD_VERSION: begin
              n.st = SSP_ST_TXSEQ;
              n.kind = SSP_K_VER;
              n.txsh = ver_char(8'h00);
            end
            default: n.st = SSP_ST_CMD;
          endcase
        end
      end
      SSP_ST_ADDR: begin
        if (byte_done) begin
          n.addr = {rxbyte, s.addr[15:8]};
          n.cnt = s.cnt + 8'h01;
          if (s.kind == SSP_K_ID ? s.cnt == SSP_ADDR_LAST_ID
              : s.cnt == SSP_ADDR_LAST_PAGE) begin
            n.cnt = '0;
            case (s.kind)
              SSP_K_READ: begin
                n.st = SSP_ST_FETCH;
                n.rd_req = 1'b1;
              end
              SSP_K_PROG: n.st = SSP_ST_DIN;
              SSP_K_ERASE: n.st = SSP_ST_CONFIRM;
              default: n.st = SSP_ST_IDSIZE;
            endcase
          end
        end
      end
      // fetch each byte before its transfer starts
      SSP_ST_FETCH: begin
        if (i_mem_rd_valid) begin
          n.txsh = i_mem_rd_data;
          n.st = SSP_ST_DOUT;
        end
      end
      SSP_ST_DOUT: begin
        if (byte_done) begin
          n.cnt = s.cnt + 8'h01;
          n.st = (s.cnt == SSP_PAGE_LAST) ? SSP_ST_CMD : SSP_ST_FETCH;
          n.rd_req = (s.cnt != SSP_PAGE_LAST);
        end
      end
      // ascending write data into the FIFO
      SSP_ST_DIN: begin
        if (byte_done) begin
          n.push = '{valid: 1'b1, data: rxbyte};
          n.cnt = s.cnt + 8'h01;
          if (s.cnt == SSP_PAGE_LAST) begin
            n.st = SSP_ST_PWAIT;
          end
        end
      end
      // program starts once all page data has left the FIFO
      SSP_ST_PWAIT: begin
        if (!o_prog_valid && !s.push.valid) begin
          n.prog_start = 1'b1;
          n.st = SSP_ST_OPWAIT;
        end
      end
      SSP_ST_OPWAIT: begin
        if (i_op_done) begin
          n.st = SSP_ST_CMD;
          n.prog_err = s.prog_err || (i_op_error && s.kind == SSP_K_PROG);
          n.erase_err = s.erase_err || (i_op_error && s.kind != SSP_K_PROG);
        end
      end
      // erase only on the confirm byte
      SSP_ST_CONFIRM: begin
        if (byte_done) begin
          n.st = (rxbyte == SSP_CMD_CONFIRM) ? SSP_ST_OPWAIT : SSP_ST_CMD;
          n.erase_blk = (rxbyte == SSP_CMD_CONFIRM) && (s.kind == SSP_K_ERASE);
          n.erase_all = (rxbyte == SSP_CMD_CONFIRM) && (s.kind == SSP_K_ERALL);
        end
      end
      SSP_ST_IDSIZE: begin
        if (byte_done) begin
          n.idsize = rxbyte;
          n.idmatch = (rxbyte == SSP_ID_LEN);
          n.id_ok = 1'b0;
          n.st = (rxbyte == 8'h00) ? SSP_ST_CMD : SSP_ST_IDDATA;
        end
      end
      // compare ID bytes first byte first
      SSP_ST_IDDATA: begin
        if (byte_done) begin
          n.cnt = s.cnt + 8'h01;
          if (s.cnt >= SSP_ID_LEN || rxbyte != i_id_code[{s.cnt[2:0], 3'h0} +: 8]) begin
            n.idmatch = 1'b0;
          end
          if (n.cnt == s.idsize) begin
            n.id_ok = n.idmatch;
            n.st = SSP_ST_CMD;
          end
        end
      end
      SSP_ST_TXSEQ: begin
        if (byte_done) begin
          n.cnt = s.cnt + 8'h01;
          if (s.kind == SSP_K_STAT) begin
            n.txsh = comm_status_register;
            n.st = (s.cnt == 8'h00) ? SSP_ST_TXSEQ : SSP_ST_CMD;
          end else begin
            n.txsh = ver_char(n.cnt);
            n.st = (s.cnt == SSP_VER_LAST) ? SSP_ST_CMD : SSP_ST_TXSEQ;
          end
        end
      end
      default: n.st = SSP_ST_CMD;
    endcase
    // busy through transfers and long operations; low when FIFO has room
    n.busy = !s.mode1 || n.inxfer || byte_done
      || n.st == SSP_ST_FETCH || n.st == SSP_ST_PWAIT || n.st == SSP_ST_OPWAIT
      || (n.st == SSP_ST_DIN && !fifo_in_ready) || s.push.valid;
  end

  // Single state register; control state cleared by reset
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      s <= '0;
      s.st <= SSP_ST_CMD;
      s.kind <= SSP_K_READ;
      s.tx <= 1'b1;
      s.txsh <= 8'hFF;
      s.busy <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from the state register
  assign o_serial_transmit_line = s.tx;
  assign o_busy_handshake_output = s.busy;
  assign o_mode1_active = s.mode1;
  assign o_mem_rd_req = s.rd_req;
  assign o_mem_addr = {s.addr, s.cnt};
  assign o_prog_start = s.prog_start;
  assign o_erase_block = s.erase_blk;
  assign o_erase_all = s.erase_all;
endmodule

/* pkg/ssp_pkg.sv */
// Constants, commands and state types of the serial flash command interpreter
package ssp_pkg;
  // Command bytes
  localparam logic [7:0] SSP_CMD_PAGE_READ = 8'hFF;
  localparam logic [7:0] SSP_CMD_PAGE_PROG = 8'h41;
  localparam logic [7:0] SSP_CMD_BLK_ERASE = 8'h20;
  localparam logic [7:0] SSP_CMD_ERASE_ALL = 8'hA7;
  localparam logic [7:0] SSP_CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] SSP_CMD_RD_STATUS = 8'h70;
  localparam logic [7:0] SSP_CMD_CLR_STATUS = 8'h50;
  localparam logic [7:0] SSP_CMD_ID_CHECK = 8'hF5;
  localparam logic [7:0] SSP_CMD_VERSION = 8'hFB;
  // Counts: last byte index of a page, of the version text, ID length
  localparam logic [7:0] SSP_PAGE_LAST = 8'hFF;
  localparam logic [7:0] SSP_VER_LAST = 8'h07;
  localparam logic [7:0] SSP_ID_LEN = 8'h07;
  localparam logic [2:0] SSP_BIT_LAST = 3'h7;
  localparam logic [1:0] SSP_STRAP_AT = 2'h2;
  // Address bytes before the payload (ID check carries a low byte too)
  localparam logic [7:0] SSP_ADDR_LAST_PAGE = 8'h01;
  localparam logic [7:0] SSP_ADDR_LAST_ID = 8'h02;
  // Primary status bit positions
  localparam int SSP_SR_READY = 7;
  localparam int SSP_SR_ERASE_ERR = 5;
  localparam int SSP_SR_PROG_ERR = 4;
  // Comm status bit position for a verified ID
  localparam int SSP_SR1_ID_OK = 2;
  // Version text, eight ASCII characters (value arbitrary)
  localparam logic [63:0] SSP_VERSION = 64'h5645_5258_3030_3031;
  // FIFO shape
  localparam int SSP_FIFO_W = 8;
  localparam int SSP_FIFO_D = 8;

  typedef enum logic [10:0] {
    SSP_ST_CMD = 11'h001,
    SSP_ST_ADDR = 11'h002,
    SSP_ST_FETCH = 11'h004,
    SSP_ST_DOUT = 11'h008,
    SSP_ST_DIN = 11'h010,
    SSP_ST_PWAIT = 11'h020,
    SSP_ST_OPWAIT = 11'h040,
    SSP_ST_CONFIRM = 11'h080,
    SSP_ST_IDSIZE = 11'h100,
    SSP_ST_IDDATA = 11'h200,
    SSP_ST_TXSEQ = 11'h400
  } ssp_state_t;

  typedef enum logic [2:0] {
    SSP_K_READ = 3'h0,
    SSP_K_PROG = 3'h1,
    SSP_K_ERASE = 3'h2,
    SSP_K_ERALL = 3'h3,
    SSP_K_ID = 3'h4,
    SSP_K_STAT = 3'h5,
    SSP_K_VER = 3'h6
  } ssp_kind_t;

  // One byte with its valid flag, carried into the FIFO
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ssp_byte_t;

  typedef struct packed {
    ssp_state_t st;
    ssp_kind_t kind;
    logic [1:0] strap_cnt;
    logic mode1;
    logic clk_s1;
    logic clk_s2;
    logic clk_q;
    logic rx_s1;
    logic rx_s2;
    logic [2:0] bitcnt;
    logic inxfer;
    logic [7:0] rxsh;
    logic [7:0] txsh;
    logic tx;
    logic busy;
    logic [7:0] cnt;
    logic [15:0] addr;
    logic [7:0] idsize;
    logic idmatch;
    logic id_ok;
    logic prog_err;
    logic erase_err;
    logic rd_req;
    logic erase_blk;
    logic erase_all;
    logic prog_start;
    ssp_byte_t push;
  } ssp_regs_t;
endpackage
